/* inc/pbs_pkg.sv */
// shared constants and carriers of the pipelined burst memory port
package pbs_pkg;

    // width variant: 1 builds words of four lanes, 0 builds words of two lanes
    localparam bit WIDE_VARIANT = 1'b1;
    // bits per byte lane, eight data bits plus one parity lane bit
    localparam int LANE_BITS = 9;
    // lanes per word in each variant
    localparam int WIDE_LANES = 4;
    localparam int NARROW_LANES = 2;
    localparam int LANES = WIDE_VARIANT ? WIDE_LANES : NARROW_LANES;
    localparam int DATA_BITS = LANES * LANE_BITS;
    // storage depth of each variant
    localparam int WIDE_DEPTH = 262144;
    localparam int NARROW_DEPTH = 524288;
    localparam int DEPTH = WIDE_VARIANT ? WIDE_DEPTH : NARROW_DEPTH;
    localparam int ADDR_BITS = $clog2(DEPTH);
    // burst counter width, four locations at most
    localparam int BURST_BITS = 2;
    // words held by the self-timed write queue
    localparam int QUEUE_DEPTH = 16;
    // reset values
    localparam logic [BURST_BITS-1:0] BURST_RESET = 2'h0;
    localparam logic [DATA_BITS-1:0] DATA_RESET = '0;
    localparam logic [ADDR_BITS-1:0] ADDR_RESET = '0;

    // kind of the access in flight
    typedef enum logic [1:0] {
        PBS_IDLE = 2'b00,
        PBS_READ = 2'b01,
        PBS_WRITE = 2'b10
    } pbs_kind_t;

    // one edge's worth of sampled synchronous pins
    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
        logic selFirstN;
        logic selHigh;
        logic selLowN;
        logic strobeCpuN;
        logic strobeCtrlN;
        logic stepN;
        logic [LANES-1:0] laneN;
        logic gateN;
        logic globalN;
    } pbs_bus_t;

    // one queued write: word address, data, lanes to change
    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
        logic [LANES-1:0] lanes;
    } pbs_wr_t;

endpackage : pbs_pkg

/* verilog/pbs_sram_port.sv */
// Operation
// [R1] all synchronous pins registered on rising edge
// [R2] address, data, selects, strobes, step, writes sampled
// [R3] address and selects load on either strobe
// [R4] later burst addresses stepped by burst step
// [R5] two-bit counter, four locations per burst
// [R6] interleaved or linear order chosen by input
// [R7] writes registered, then finished internally
// [R8] lane writes change only selected lanes
// [R9] global write low writes every lane
// [R10] output enable and sleep gate drivers asynchronously
// [R11] read data registered, pipelined read path
// [R12] first word third clock, then one each
// [R13] deselect turns outputs off within one clock
// [R14] storage of the built width variant
// [R15] counter drives low two address bits only
// [R16] controller holds step high to pause
// [R17] access needs first low, high, low selects
`timescale 1ns/1ps

// self-timed write queue, valid and ready on both sides
module pbs_write_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_BITS = $clog2(DEPTH);

    // pointers carry one wrap bit so full and empty differ
    typedef struct packed {
        logic [PTR_BITS:0] wrPtr;
        logic [PTR_BITS:0] rdPtr;
    } pbs_queue_t;

    pbs_queue_t q;
    pbs_queue_t next_q;
    // queued words
    logic [WIDTH-1:0] slots [DEPTH];
    logic full;
    logic empty;

    // honest flags from the pointer pair
    assign empty = (q.wrPtr == q.rdPtr);
    assign full = (q.wrPtr[PTR_BITS] != q.rdPtr[PTR_BITS])
        && (q.wrPtr[PTR_BITS-1:0] == q.rdPtr[PTR_BITS-1:0]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = slots[q.rdPtr[PTR_BITS-1:0]];

    // pointer advance on each accepted push or pop
    always_comb begin
        next_q = q;
        if (inValid && !full) begin
            next_q.wrPtr = q.wrPtr + 1'b1;
        end
        if (outReady && !empty) begin
            next_q.rdPtr = q.rdPtr + 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // slot storage, no reset needed for data
    always_ff @(posedge clk) begin
        if (inValid && !full) begin
            slots[q.wrPtr[PTR_BITS-1:0]] <= inData;
        end
    end
endmodule : pbs_write_queue

// pipelined burst memory port, device side
module pbs_sram_port (
    input wire logic clk,
    input wire logic srst,
    input wire logic [pbs_pkg::ADDR_BITS-1:0] address,
    input wire logic [pbs_pkg::DATA_BITS-1:0] dataIn,
    output logic [pbs_pkg::DATA_BITS-1:0] dataOut,
    output logic dataOutEn,
    input wire logic select_first_n,
    input wire logic select_depth_high,
    input wire logic select_depth_low_n,
    input wire logic strobe_from_cpu_n,
    input wire logic strobe_from_ctrl_n,
    input wire logic burst_step_n,
    input wire logic [pbs_pkg::LANES-1:0] lane_write_n,
    input wire logic lane_write_gate_n,
    input wire logic global_write_n,
    input wire logic outEnable_n,
    input wire logic sleep_request,
    input wire logic burstLinear,
    output logic writeQueueReady,
    output logic writeQueueEmpty
);
    // whole port state in one record
    typedef struct packed {
        pbs_pkg::pbs_bus_t smp;
        logic active;
        pbs_pkg::pbs_kind_t kind;
        logic [pbs_pkg::ADDR_BITS-1:0] base;
        logic [pbs_pkg::BURST_BITS-1:0] startLsb;
        logic [pbs_pkg::BURST_BITS-1:0] count;
        logic [pbs_pkg::DATA_BITS-1:0] rdData;
        logic outActive;
    } pbs_port_t;

    pbs_port_t st;
    pbs_port_t next_st;

    // storage array, sized by the variant
    // [R14] variant storage depth
    logic [pbs_pkg::DATA_BITS-1:0] mem [pbs_pkg::DEPTH];

    // decoded view of the sampled edge
    logic startReq;
    logic selOk;
    logic cycleOp;
    logic stepNow;
    logic [pbs_pkg::BURST_BITS-1:0] cycleCount;
    logic [pbs_pkg::ADDR_BITS-1:0] cycleAddr;
    logic [pbs_pkg::LANES-1:0] wrLanes;
    logic isWrite;
    logic isRead;
    // queue sides
    pbs_pkg::pbs_wr_t pushWord;
    pbs_pkg::pbs_wr_t drainWord;
    logic pushValid;
    logic drainValid;
    logic drainReady;

    // burst offset from start bits and step count
    function automatic logic [pbs_pkg::BURST_BITS-1:0] burstLsb(
        input logic [pbs_pkg::BURST_BITS-1:0] start,
        input logic [pbs_pkg::BURST_BITS-1:0] cnt,
        input logic linear
    );
        logic [pbs_pkg::BURST_BITS-1:0] res;
        res = start ^ cnt;
        if (linear) begin
            res = start + cnt;
        end
        return res;
    endfunction : burstLsb

    // lanes a write touches, global write first
    function automatic logic [pbs_pkg::LANES-1:0] laneMask(
        input pbs_pkg::pbs_bus_t s
    );
        logic [pbs_pkg::LANES-1:0] res;
        res = '0;
        // [R9] global write takes all lanes
        if (!s.globalN) begin
            res = '1;
        end else if (!s.gateN) begin
            res = ~s.laneN;
        end
        return res;
    endfunction : laneMask

    // decode of the edge held in the input registers
    always_comb begin
        // [R3] either strobe loads
        startReq = !st.smp.strobeCpuN || !st.smp.strobeCtrlN;
        // [R17] select pattern check
        selOk = !st.smp.selFirstN && st.smp.selHigh && !st.smp.selLowN;
        cycleOp = (startReq && selOk) || (!startReq && st.active);
        // [R4] active-low step advances
        stepNow = !startReq && st.active && !st.smp.stepN;
        // [R5] two-bit wrap, four words
        cycleCount = stepNow ? st.count + 1'b1 : st.count;
        if (startReq) begin
            cycleCount = pbs_pkg::BURST_RESET;
        end
        // [R15] upper bits stay at loaded value
        cycleAddr = st.base;
        // [R6] order set by static input
        cycleAddr[pbs_pkg::BURST_BITS-1:0] = burstLsb(st.startLsb, cycleCount, burstLinear);
        if (startReq) begin
            cycleAddr = st.smp.addr;
        end
        // cpu strobe always opens a read, writes follow later
        wrLanes = laneMask(st.smp);
        isWrite = cycleOp && (wrLanes != '0) && st.smp.strobeCpuN;
        isRead = cycleOp && !isWrite;
    end

    // next state of the port
    always_comb begin
        next_st = st;
        // [R1] every synchronous pin sampled each edge
        // [R2] full synchronous set
        next_st.smp.addr = address;
        next_st.smp.data = dataIn;
        next_st.smp.selFirstN = select_first_n;
        next_st.smp.selHigh = select_depth_high;
        next_st.smp.selLowN = select_depth_low_n;
        next_st.smp.strobeCpuN = strobe_from_cpu_n;
        next_st.smp.strobeCtrlN = strobe_from_ctrl_n;
        next_st.smp.stepN = burst_step_n;
        next_st.smp.laneN = lane_write_n;
        next_st.smp.gateN = lane_write_gate_n;
        next_st.smp.globalN = global_write_n;
        // strobe restarts the burst from the pins
        if (startReq) begin
            next_st.active = selOk;
            next_st.base = st.smp.addr;
            next_st.startLsb = st.smp.addr[pbs_pkg::BURST_BITS-1:0];
        end
        next_st.count = cycleCount;
        // [R11] read word captured into output register
        // [R12] pins, input stage, output stage
        // [R13] deselect drops drivers next edge
        next_st.outActive = isRead;
        if (isRead) begin
            next_st.rdData = mem[cycleAddr];
        end
        // kind tracking, idle when nothing runs
        case ({isWrite, isRead})
            2'b10: begin
                next_st.kind = pbs_pkg::PBS_WRITE;
            end
            2'b01: begin
                next_st.kind = pbs_pkg::PBS_READ;
            end
            default: begin
                next_st.kind = pbs_pkg::PBS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // [R7] registered write handed to the queue
    assign pushValid = isWrite;
    assign pushWord.addr = cycleAddr;
    assign pushWord.data = st.smp.data;
    assign pushWord.lanes = wrLanes;

    // array port is busy on reads; write cycles drain too, so the queue holds one word at most
    assign drainReady = !isRead;

    pbs_write_queue #(
        .WIDTH($bits(pbs_pkg::pbs_wr_t)),
        .DEPTH(pbs_pkg::QUEUE_DEPTH)
    ) writeQueue (
        .clk(clk),
        .srst(srst),
        .inValid(pushValid),
        .inReady(writeQueueReady),
        .inData(pushWord),
        .outValid(drainValid),
        .outReady(drainReady),
        .outData(drainWord)
    );

    assign writeQueueEmpty = !drainValid;

    // self-timed array write, one queued word per free cycle
    always_ff @(posedge clk) begin
        if (drainValid && drainReady) begin
            for (int i = 0; i < pbs_pkg::LANES; i++) begin
                // [R8] unselected lanes keep contents
                if (drainWord.lanes[i]) begin
                    mem[drainWord.addr][i*pbs_pkg::LANE_BITS +: pbs_pkg::LANE_BITS]
                        <= drainWord.data[i*pbs_pkg::LANE_BITS +: pbs_pkg::LANE_BITS];
                end
            end
        end
    end

    // data pins come straight from the output register
    assign dataOut = st.rdData;
    // [R10] asynchronous driver gate
    assign dataOutEn = st.outActive && !outEnable_n && !sleep_request;

    // pins of a read strobe with the device selected
    sequence s_pinRead;
        !strobe_from_ctrl_n && !select_first_n && select_depth_high
            && !select_depth_low_n && global_write_n && lane_write_gate_n;
    endsequence

    // pins of a strobe that misses the select pattern
    sequence s_pinDeselect;
        !strobe_from_ctrl_n && select_first_n;
    endsequence

    // the input stage then holds the same strobe
    sequence s_sampled;
        startReq;
    endsequence

    // [R3] load on a selected strobe
    a_strobe_load: assert property (@(posedge clk) disable iff (srst) // [R3]
        startReq && selOk |=> st.active && st.base == $past(st.smp.addr))
        else $error("address not loaded on strobe");

    // [R15] upper bits fixed in burst
    a_upper_hold: assert property (@(posedge clk) disable iff (srst) // [R15]
        !startReq && st.active |-> cycleAddr[pbs_pkg::ADDR_BITS-1:pbs_pkg::BURST_BITS]
            == st.base[pbs_pkg::ADDR_BITS-1:pbs_pkg::BURST_BITS])
        else $error("upper address moved during burst");

    // [R4] step moves counter by one
    a_step_count: assert property (@(posedge clk) disable iff (srst) // [R4]
        stepNow |=> st.count == $past(st.count) + 2'h1)
        else $error("burst step did not advance counter");

    // [R16] paused burst holds position
    a_pause_hold: assert property (@(posedge clk) disable iff (srst) // [R16]
        !startReq && st.active && st.smp.stepN |=> $stable(st.count))
        else $error("counter moved while paused");

    // [R12] first word on third clock
    a_first_word: assert property (@(posedge clk) disable iff (srst) // [R12]
        s_pinRead ##1 s_sampled |-> ##1 st.outActive)
        else $error("first read word not ready on third clock");

    // [R13] single cycle deselect
    a_deselect_one: assert property (@(posedge clk) disable iff (srst) // [R13]
        s_pinDeselect ##1 s_sampled |-> ##1 !dataOutEn && !st.active)
        else $error("outputs not deselected within one clock");

    // [R10] output enable high turns drivers off
    a_oe_gate: assert property (@(posedge clk) disable iff (srst) // [R10]
        outEnable_n || sleep_request |-> !dataOutEn)
        else $error("drivers on while disabled");

    // [R9] global write covers all lanes
    a_global_all: assert property (@(posedge clk) disable iff (srst) // [R9]
        isWrite && !st.smp.globalN |-> pushWord.lanes == '1)
        else $error("global write missed a lane");

    // [R11] read word captured and presented on the edge after the read decode
    a_read_pipe: assert property (@(posedge clk) disable iff (srst) // [R11]
        isRead |=> st.outActive && st.kind == pbs_pkg::PBS_READ)
        else $error("read data not registered");

    // [R7] no drain while the array is read
    a_drain_block: assert property (@(posedge clk) disable iff (srst) // [R7]
        isRead |-> !drainReady)
        else $error("queue drained during a read");

    // [R7] accepted write lands in the queue
    a_write_queued: assert property (@(posedge clk) disable iff (srst) // [R7]
        isWrite && writeQueueReady |=> !writeQueueEmpty)
        else $error("registered write not queued");
endmodule : pbs_sram_port

/* dv/pbs_cpu_model.sv */
`timescale 1ns/1ps
// controller model: drives the pins just after the falling edge, keeps reference words
module pbs_cpu_model (
    input wire logic clk,
    output logic [pbs_pkg::ADDR_BITS-1:0] address,
    output logic [pbs_pkg::DATA_BITS-1:0] dataIn,
    output logic [2:0] sel,
    output logic cpuN,
    output logic ctrlN,
    output logic stepN,
    output logic [pbs_pkg::LANES-1:0] laneN,
    output logic gateN,
    output logic globalN,
    output logic burstLinear
);
    localparam int LB = pbs_pkg::LANE_BITS; // lane slice width
    int cyc = 0; // rising edges seen
    logic [pbs_pkg::DATA_BITS-1:0] refMem [int]; // words the array should hold
    logic [pbs_pkg::DATA_BITS-1:0] expQ [$]; // words due on dataOut
    int dueQ [$]; // edge count at which each word is due

    // edge counter for latency checks
    always @(posedge clk) cyc <= cyc + 1;

    // every pin but burstLinear set once per call, so nothing glitches within a time step
    task automatic drive(input logic [2:0] s, input logic c, input logic k, input logic sn,
            input logic g, input logic [pbs_pkg::LANES-1:0] l, input logic w,
            input logic [pbs_pkg::ADDR_BITS-1:0] a, input logic [pbs_pkg::DATA_BITS-1:0] d);
        sel = s;
        {cpuN, ctrlN, stepN, gateN, globalN} = {c, k, sn, g, w};
        laneN = l;
        address = a;
        dataIn = d;
    endtask : drive

    // released pins wander, so a stale value is never trusted
    task automatic idle(input logic ctrl, input logic step);
        drive(3'h4, 1'b1, ctrl, step, 1'b1, '1, 1'b1, pbs_pkg::ADDR_BITS'($urandom()),
            pbs_pkg::DATA_BITS'({$urandom(), $urandom()}));
    endtask : idle

    // strobe with a bad select ends any burst, then release
    task automatic endsel();
        @(negedge clk);
        idle(1'b0, 1'b1);
        @(negedge clk);
        idle(1'b1, 1'b1);
    endtask : endsel

    // one write access; the deselect stops a burst write following it
    task automatic write(input int a, input logic [pbs_pkg::DATA_BITS-1:0] d, input logic gN,
            input logic [pbs_pkg::LANES-1:0] lN, input logic wN);
        logic [pbs_pkg::DATA_BITS-1:0] w;
        w = refMem.exists(a) ? refMem[a] : '0;
        @(negedge clk);
        drive(3'h2, 1'b1, 1'b0, 1'b1, gN, lN, wN, pbs_pkg::ADDR_BITS'(a), d);
        for (int i = 0; i < pbs_pkg::LANES; i++)
            if (!wN || (!gN && !lN[i])) w[i*LB +: LB] = d[i*LB +: LB];
        refMem[a] = w;
        endsel();
    endtask : write

    // read burst of n cycles; steps bit k is the step request of cycle k
    task automatic burst(input int a, input logic viaCpu, input int n, input logic [7:0] steps,
            input logic lin, input logic [2:0] s, input logic show);
        logic [1:0] cnt;
        logic [1:0] low;
        cnt = 2'h0;
        burstLinear = lin;
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            if (k == 0) begin
                // selects and address taken with a strobe only
                // cpu strobe must read even with lane writes requested
                drive(s, !viaCpu, viaCpu, 1'b1, !viaCpu, {pbs_pkg::LANES{!viaCpu}}, 1'b1,
                    pbs_pkg::ADDR_BITS'(a), pbs_pkg::DATA_BITS'({$urandom(), $urandom()}));
            end else begin
                // step held high pauses the counter
                idle(1'b1, !steps[k]);
                cnt = cnt + 2'(steps[k]);
            end
            // counter feeds the low two bits only
            low = lin ? a[1:0] + cnt : a[1:0] ^ cnt;
            if (show && s == 3'h2) begin
                expQ.push_back(refMem[{a[31:2], low}]);
                dueQ.push_back(cyc + 2);
            end
        end
        endsel();
    endtask : burst

    // pins defined from time zero
    initial begin
        burstLinear = 1'b1;
        idle(1'b1, 1'b1);
    end
endmodule : pbs_cpu_model

/* dv/test_pipelined_burst_sram_port.sv */
`timescale 1ns/1ps
`define CHK(g, e) check(64'(g), 64'(e))
// self-checking bench of the pipelined burst memory port
module test_pipelined_burst_sram_port;
    logic clk = 1'b0; // 125 MHz
    logic srst = 1'b1; // sync reset
    logic outEnable_n = 1'b0; // async output enable
    logic sleep_request = 1'b0; // async driver gate
    logic [pbs_pkg::ADDR_BITS-1:0] address;
    logic [pbs_pkg::DATA_BITS-1:0] dataIn;
    logic [pbs_pkg::DATA_BITS-1:0] dataOut;
    logic [pbs_pkg::LANES-1:0] laneN;
    logic [2:0] sel; // first, high, low selects
    logic dataOutEn, cpuN, ctrlN, stepN, gateN, globalN, burstLinear;
    logic writeQueueReady, writeQueueEmpty;
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3}; // each breaks one select
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int base = 32'h124; // start of a four-word block
    int rs;

    initial forever #4 clk = ~clk;

    pbs_cpu_model cpu (.clk(clk), .address(address), .dataIn(dataIn), .sel(sel), .cpuN(cpuN),
        .ctrlN(ctrlN), .stepN(stepN), .laneN(laneN), .gateN(gateN), .globalN(globalN),
        .burstLinear(burstLinear));

    pbs_sram_port dut (.clk(clk), .srst(srst), .address(address), .dataIn(dataIn),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .select_first_n(sel[2]),
        .select_depth_high(sel[1]), .select_depth_low_n(sel[0]), .strobe_from_cpu_n(cpuN),
        .strobe_from_ctrl_n(ctrlN), .burst_step_n(stepN), .lane_write_n(laneN),
        .lane_write_gate_n(gateN), .global_write_n(globalN), .outEnable_n(outEnable_n),
        .sleep_request(sleep_request), .burstLinear(burstLinear),
        .writeQueueReady(writeQueueReady), .writeQueueEmpty(writeQueueEmpty));

    // four-state compare, counted
    task automatic check(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    function automatic logic [pbs_pkg::DATA_BITS-1:0] rnd();
        return pbs_pkg::DATA_BITS'({$urandom(), $urandom()});
    endfunction : rnd

    // bounded wait; reads before the drain could see old words
    task automatic drain();
        for (int t = 0; t < 64 && writeQueueEmpty !== 1'b1; t++) @(negedge clk);
        `CHK({writeQueueEmpty, writeQueueReady}, 2'h3);
        @(negedge clk);
    endtask : drain

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    // output watcher: each driven word must be the oldest noted, on time
    always begin
        @(posedge clk);
        #2;
        if (!srst && dataOutEn === 1'b1) begin
            if (cpu.expQ.size() == 0) begin
                `CHK(dataOutEn, 1'b0);
            end else begin
                `CHK(dataOut, cpu.expQ.pop_front());
                `CHK(cpu.cyc, cpu.dueQ.pop_front());
            end
        end
    end

    initial begin
        rs = $urandom(32'hB095);
        repeat (3) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        `CHK({dataOutEn, writeQueueReady, writeQueueEmpty}, 3'h3);
        // global write ignores lane controls, then partial lanes
        for (int i = 0; i < 4; i++) cpu.write(base + i, rnd(), 1'b1, '0, 1'b0);
        cpu.write(base + 1, rnd(), 1'b0, 4'hE, 1'b1);
        cpu.write(base + 2, rnd(), 1'b0, 4'h3, 1'b1);
        repeat (6) cpu.write(base + int'($urandom() & 3), rnd(), 1'b0, 4'($urandom() % 15), 1'b1);
        drain();
        $display("test writes done");
        // wrap in both orders, a paused burst, a short one
        cpu.burst(base + 2, 1'b1, 4, 8'hFF, 1'b1, 3'h2, 1'b1);
        cpu.burst(base + 3, 1'b0, 4, 8'hFF, 1'b0, 3'h2, 1'b1);
        cpu.burst(base + 1, 1'b0, 6, 8'h76, 1'b0, 3'h2, 1'b1);
        cpu.burst(base, 1'b0, 2, 8'hFF, 1'b1, 3'h2, 1'b1);
        // wrong selects start nothing
        foreach (bad[j]) cpu.burst(base, 1'b0, 1, 8'h00, 1'b1, bad[j], 1'b1);
        $display("test bursts done");
        outEnable_n = 1'b1;
        cpu.burst(base, 1'b0, 3, 8'hFF, 1'b1, 3'h2, 1'b0);
        outEnable_n = 1'b0;
        sleep_request = 1'b1;
        cpu.burst(base, 1'b1, 3, 8'hFF, 1'b0, 3'h2, 1'b0);
        sleep_request = 1'b0;
        $display("test gating done");
        // random start, order, steps and strobe
        repeat (20) cpu.burst(base + int'($urandom() & 3), 1'($urandom()),
            1 + int'($urandom() % 6), 8'($urandom()), 1'($urandom()), 3'h2, 1'b1);
        repeat (4) @(negedge clk);
        `CHK(cpu.expQ.size(), 0);
        $display("test random done");
        final_report();
    end
endmodule : test_pipelined_burst_sram_port
